//--- hw/dic_map.svh
`ifndef DIC_MAP_SVH
`define DIC_MAP_SVH
// ****************************************
// Register offsets on the APB slave.
// ****************************************
`define DIC_STATUS_OFF 12'h000
`define DIC_STACK_OFF 12'h004
`define DIC_PEND_OFF 12'h008
`define DIC_VEC_OFF 12'h00c
// ****************************************
// Field positions and reset values.
// ****************************************
`define DIC_NCAUSE 10
`define DIC_GMASK_BIT 15
`define DIC_LF_BIT 12
`define DIC_STATUS_RST 16'hf000
`define DIC_STACK_RST 16'hffff
// ****************************************
// Vector table.
// ****************************************
`define DIC_VEC_BASE 16'h0200
`define DIC_VEC_FIRST 16'h0210
`endif

//--- hw/dic_pkg.sv
package dic_pkg;
   // Cause vector, bit 0 is external pin 1, bit 9 the host output cause.
   typedef logic [9:0] dic_cause_t;
   // Instruction address handed to the sequencer.
   typedef logic [15:0] dic_addr_t;
   // Controller sequencing.
   typedef enum logic [0:0] {
      DIC_RESET_VEC,
      DIC_RUN
   } dic_state_e;
endpackage : dic_pkg

//--- hw/dic_controller.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "dic_map.svh"
// Function
// - Exactly ten causes, six internal and four external pins.
// - Serial 1/2 input done, output ready, host input done, output ready.
// - External pins request only on a high-to-low transition.
// - Each cause has its own independent mask bit.
// - One global mask blocks every cause together.
// - The global mask is backed by a hardware stack for nesting.
// - Acknowledge only when global mask and cause mask both read 0.
// - Acknowledge aborts the current instruction and forces the vector.
// - Return from interrupt resumes the aborted instruction.
// - Postpone acknowledge while a jump is fetched, decoded or executed.
// - Postpone while a repeat or its repeated instruction is in flight.
// - Postpone during loop setup and loop end instruction fetch.
// - Vectors fill a 64-word table at 0x200, four words each.
// - Reset 0x200, pins 0x210-0x21c, serial 0x220-0x22c, host 0x230/0x234.
// - Reset is vector zero, first fetch at 0x200.
// - On acknowledge the stack shifts right and its top bit sets.
// - On return the stack shifts left, loading 1 at the bottom.
// - Cause masks keep their value on acknowledge.
// - Status register resets to 0xf000, all interrupts blocked.
module dic_controller (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial1_rx_done,
   input wire logic serial1_tx_ready,
   input wire logic serial2_rx_done,
   input wire logic serial2_tx_ready,
   input wire logic host_rx_done,
   input wire logic parallel_tx_ready,
   input wire logic ext_irq_pin_1,
   input wire logic ext_irq_pin_2,
   input wire logic ext_irq_pin_3,
   input wire logic ext_irq_pin_4,
   input wire logic jump_busy,
   input wire logic repeat_busy,
   input wire logic loop_busy,
   input wire logic loop_end_fetch,
   input wire logic loop_flag,
   input wire logic irq_return_instr,
   output logic pc_force,
   output dic_pkg::dic_addr_t pc_vector
);
   import dic_pkg::*;

   // ****************************************
   // Helper functions.
   // ****************************************

   // Index of the lowest set bit, which is the lowest vector address.
   function automatic logic [3:0] first_set(input dic_cause_t v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = `DIC_NCAUSE - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : first_set

   // Four instruction words per entry above the first pin entry.
   function automatic dic_addr_t cause_vector(input logic [3:0] idx);
      return `DIC_VEC_FIRST + {10'h000, idx, 2'b00};
   endfunction : cause_vector

   // ****************************************
   // State and signals.
   // ****************************************
   dic_state_e state;
   logic [3:0] pin_prev;
   logic [3:0] pin_now;
   dic_cause_t cause_event;
   dic_cause_t pend;
   dic_cause_t next_pend;
   dic_cause_t cause_mask;
   dic_cause_t ready_vec;
   dic_cause_t take_onehot;
   logic [15:0] mask_stack_reg;
   logic loop_flag_q;
   logic defer;
   logic take;
   logic [3:0] take_idx;
   logic acc;
   logic wr_en;
   logic hit;
   logic [15:0] rd_val;
   logic [15:0] status_reg;

   // ****************************************
   // Cause collection.
   // ****************************************

   // Pins are taken as synchronous; only a falling edge makes a request.
   assign pin_now = {ext_irq_pin_4, ext_irq_pin_3, ext_irq_pin_2, ext_irq_pin_1};
   assign cause_event = {parallel_tx_ready, host_rx_done,
                         serial2_tx_ready, serial2_rx_done,
                         serial1_tx_ready, serial1_rx_done,
                         pin_prev & ~pin_now};

   // Previous pin level; reset high so a pin held low at reset counts as a falling edge once reset ends.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_prev <= 4'hf;
      end else begin
         pin_prev <= pin_now;
      end
   end

   // A new event in the acknowledge cycle survives: set wins over clear.
   assign take_onehot = take ? dic_cause_t'(10'h001 << take_idx) : 10'h000;
   assign next_pend = (pend & ~take_onehot) | cause_event;

   // Pending latches.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pend <= 10'h000;
      end else begin
         pend <= next_pend;
      end
   end

   // ****************************************
   // Acknowledge decision.
   // ****************************************

   // Hold off while the sequencer cannot be safely redirected.
   assign defer = jump_busy | repeat_busy | loop_busy | loop_end_fetch;
   assign ready_vec = pend & ~cause_mask;
   assign take_idx = first_set(ready_vec);
   assign take = (state == DIC_RUN) && (ready_vec != 10'h000) &&
                 !mask_stack_reg[`DIC_GMASK_BIT] && !defer;

   // Reset vector is issued once, then normal arbitration runs.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= DIC_RESET_VEC;
      end else begin
         case (state)
            DIC_RESET_VEC: state <= DIC_RUN;
            DIC_RUN: state <= DIC_RUN;
            default: state <= DIC_RUN;
         endcase
      end
   end

   // Redirect pulse and vector; the sequencer aborts its current instruction.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pc_force <= 1'b0;
         pc_vector <= `DIC_VEC_BASE;
      end else if (state == DIC_RESET_VEC) begin
         pc_force <= 1'b1;
         pc_vector <= `DIC_VEC_BASE;
      end else if (take) begin
         pc_force <= 1'b1;
         pc_vector <= cause_vector(take_idx);
      end else begin
         pc_force <= 1'b0;
      end
   end

   // ****************************************
   // Mask stack and cause masks.
   // ****************************************
   assign acc = psel && penable && pready;
   assign wr_en = acc && pwrite;

   // Stack moves win over a software write in the same cycle, so nesting
   // is never corrupted. The sequencer itself keeps the return address.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_stack_reg <= `DIC_STACK_RST;
      end else if (take) begin
         mask_stack_reg <= {1'b1, mask_stack_reg[15:1]};
      end else if (irq_return_instr) begin
         mask_stack_reg <= {mask_stack_reg[14:0], 1'b1};
      end else if (wr_en && paddr == `DIC_STACK_OFF) begin
         mask_stack_reg <= pwdata[15:0];
      end else if (wr_en && paddr == `DIC_STATUS_OFF) begin
         mask_stack_reg[15:13] <= pwdata[15:13];
      end
   end

   // Cause masks change only by software write, never by an acknowledge.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cause_mask <= 10'h000;
      end else if (wr_en && paddr == `DIC_STATUS_OFF) begin
         cause_mask <= pwdata[9:0];
      end
   end

   // Loop flag copy, shown in the status register.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         loop_flag_q <= 1'b1;
      end else begin
         loop_flag_q <= loop_flag;
      end
   end

   // ****************************************
   // APB slave.
   // ****************************************
   assign status_reg = {mask_stack_reg[15:13], loop_flag_q, 2'b00, cause_mask};

   // Address decode for reads.
   always_comb begin
      hit = 1'b1;
      rd_val = 16'h0000;
      if (paddr == `DIC_STATUS_OFF) begin
         rd_val = status_reg;
      end else if (paddr == `DIC_STACK_OFF) begin
         rd_val = mask_stack_reg;
      end else if (paddr == `DIC_PEND_OFF) begin
         rd_val = {6'h00, pend};
      end else if (paddr == `DIC_VEC_OFF) begin
         rd_val = pc_vector;
      end else begin
         hit = 1'b0;
      end
   end

   // One wait state keeps every bus output straight from a flip-flop.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !hit;
         prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ****************************************
   // Assertions.
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_reset_vec;
      $past(reset) |=> pc_force && pc_vector == `DIC_VEC_BASE;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("reset vector not issued");

   property p_reset_mask;
      $past(reset) |-> status_reg[15:13] == 3'h7 && cause_mask == 10'h000;
   endproperty
   a_reset_mask: assert property (p_reset_mask)
      else $error("status not at reset value");

   property p_vector;
      take |=> pc_force && pc_vector == `DIC_VEC_FIRST + {10'h000, $past(take_idx), 2'b00};
   endproperty
   a_vector: assert property (p_vector)
      else $error("wrong vector after acknowledge");

   property p_open;
      pc_force && $past(state) == DIC_RUN |->
         !$past(mask_stack_reg[15]) && ($past(pend) & ~$past(cause_mask)) != 10'h000;
   endproperty
   a_open: assert property (p_open)
      else $error("acknowledge while masked");

   property p_defer;
      defer && state == DIC_RUN ##0 $past(state) == DIC_RUN |=> !pc_force;
   endproperty
   a_defer: assert property (p_defer)
      else $error("acknowledge during busy sequencer");

   property p_push;
      take |=> mask_stack_reg == {1'b1, $past(mask_stack_reg[15:1])};
   endproperty
   a_push: assert property (p_push)
      else $error("mask stack not pushed");

   property p_pop;
      irq_return_instr && !take |=> mask_stack_reg == {$past(mask_stack_reg[14:0]), 1'b1};
   endproperty
   a_pop: assert property (p_pop)
      else $error("mask stack not popped");

   property p_keep_mask;
      take && !wr_en |=> cause_mask == $past(cause_mask);
   endproperty
   a_keep_mask: assert property (p_keep_mask)
      else $error("cause mask changed by acknowledge");

   property p_edge;
      $fell(ext_irq_pin_1) |=> pend[0];
   endproperty
   a_edge: assert property (p_edge)
      else $error("falling edge not latched");

   property p_level;
      !pin_prev[1] && !ext_irq_pin_2 && !pend[1] |=> !pend[1];
   endproperty
   a_level: assert property (p_level)
      else $error("steady low made a request");

   property p_priority;
      take |-> (ready_vec & ((10'h001 << take_idx) - 10'h001)) == 10'h000;
   endproperty
   a_priority: assert property (p_priority)
      else $error("lower vector skipped");

endmodule : dic_controller

//--- testbench/dic_source_model.sv
`timescale 1ns/100ps
// ****
// External request source model.
// ****
module dic_source_model (
   input wire logic sys_clk,
   input wire logic [3:0] fire,
   output logic [3:0] pin
);
   logic [4:0] hold [4] = '{default: 5'h0};
   // A request is a fall held low twenty cycles, then a return high, so the
   // next request always shows the controller a fresh falling edge.
   always @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (fire[i]) begin
            pin[i] <= 1'b0;
            hold[i] <= 5'h14;
         end else if (hold[i] != 5'h0) begin
            hold[i] <= hold[i] - 5'h1;
         end else begin
            pin[i] <= 1'b1;
         end
      end
   end
endmodule : dic_source_model

//--- testbench/dic_controller_tb_top.sv
`timescale 1ns/100ps
`include "dic_map.svh"
// ****
// Bench for the interrupt controller.
// ****
module dic_controller_tb_top;
   import dic_pkg::*;
   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, pc_force, irq_ret, err, lflag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] ev;
   logic [3:0] fire, pin, busy;
   dic_addr_t pc_vector;
   int fails, samples_checked, cyc;
   dic_controller dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial1_rx_done(ev[0]), .serial1_tx_ready(ev[1]),
      .serial2_rx_done(ev[2]), .serial2_tx_ready(ev[3]), .host_rx_done(ev[4]),
      .parallel_tx_ready(ev[5]), .ext_irq_pin_1(pin[0]), .ext_irq_pin_2(pin[1]),
      .ext_irq_pin_3(pin[2]), .ext_irq_pin_4(pin[3]), .jump_busy(busy[0]),
      .repeat_busy(busy[1]), .loop_busy(busy[2]), .loop_end_fetch(busy[3]),
      .loop_flag(lflag), .irq_return_instr(irq_ret), .pc_force(pc_force),
      .pc_vector(pc_vector));
   dic_source_model src_u (.sys_clk(sys_clk), .fire(fire), .pin(pin));
   // Clock and a cycle ceiling, so a hung wait still reaches the verdict.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report;
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One APB transfer; request held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   // Watch a window; exp of zero means no redirect may appear.
   task automatic expect_force(input logic [15:0] exp, input int lim);
      logic got;
      got = 1'b0;
      repeat (lim) begin
         @(posedge sys_clk);
         if (pc_force === 1'b1 && !got) begin
            got = 1'b1;
            chk("pc_vector", {16'h0, pc_vector}, {16'h0, exp});
         end
      end
      chk("pc_force", {31'h0, got}, {31'h0, exp != 16'h0});
   endtask : expect_force
   task automatic raise(input int i);
      if (i < 4) fire[i] <= 1'b1;
      else ev[i - 4] <= 1'b1;
      @(posedge sys_clk);
      fire <= 4'h0;
      ev <= 6'h0;
      // Let an edge pass, so a following request never reassigns these in this step.
      @(posedge sys_clk);
   endtask : raise
   task automatic ret;
      irq_ret <= 1'b1;
      @(posedge sys_clk);
      irq_ret <= 1'b0;
   endtask : ret
   task automatic t_reset;
      expect_force(16'h0200, 4);
      apb(1'b0, `DIC_STATUS_OFF, 0);
      chk("status", rd, 32'hf000);
      apb(1'b0, `DIC_STACK_OFF, 0);
      chk("stack", rd, 32'hffff);
      apb(1'b0, 12'h010, 0);
      chk("slverr", {31'h0, err}, 32'h1);
      // A loop flag of zero must show through in status bit 12.
      lflag <= 1'b0;
      apb(1'b0, `DIC_STATUS_OFF, 0);
      chk("loop flag", rd, 32'he000);
      lflag <= 1'b1;
      $display("reset test done");
   endtask : t_reset
   // Every cause in turn, with the stack pushed and popped around each.
   task automatic t_causes;
      apb(1'b1, `DIC_STACK_OFF, 0);
      apb(1'b1, `DIC_STATUS_OFF, 0);
      for (int i = 0; i < 10; i++) begin
         raise(i);
         expect_force(16'h0210 + 16'(4 * i), 6);
         apb(1'b0, `DIC_STATUS_OFF, 0);
         chk("status", rd, 32'h9000);
         apb(1'b0, `DIC_PEND_OFF, 0);
         chk("pending", rd, 0);
         ret;
         expect_force(0, 4);
         apb(1'b0, `DIC_STACK_OFF, 0);
         chk("stack", rd, 32'h0001);
      end
      $display("cause test done");
   endtask : t_causes
   // A masked cause waits while a neighbour is served, then runs on unmask.
   task automatic t_mask;
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, `DIC_STATUS_OFF, 32'h1 << i);
         raise(i);
         raise((i + 1) % 10);
         expect_force(16'h0210 + 16'(4 * ((i + 1) % 10)), 6);
         ret;
         apb(1'b0, `DIC_PEND_OFF, 0);
         chk("pending", rd, 32'h1 << i);
         apb(1'b1, `DIC_STATUS_OFF, 0);
         expect_force(16'h0210 + 16'(4 * i), 6);
         ret;
         expect_force(0, 4);
      end
      $display("mask test done");
   endtask : t_mask
   task automatic t_busy;
      for (int b = 0; b < 4; b++) begin
         busy[b] <= 1'b1;
         raise(4);
         expect_force(0, 8);
         busy[b] <= 1'b0;
         expect_force(16'h0220, 6);
         ret;
      end
      $display("busy test done");
   endtask : t_busy
   // Global mask holds two causes; the lower vector goes first.
   task automatic t_prio;
      apb(1'b1, `DIC_STACK_OFF, 32'h8000);
      raise(9);
      raise(2);
      expect_force(0, 6);
      apb(1'b1, `DIC_STACK_OFF, 0);
      expect_force(16'h0218, 6);
      ret;
      expect_force(16'h0234, 6);
      apb(1'b0, `DIC_VEC_OFF, 0);
      chk("last vector", rd, 32'h0234);
      ret;
      $display("priority test done");
   endtask : t_prio
   task automatic final_report;
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, irq_ret} = 4'h0;
      {paddr, pwdata, ev, fire, busy} = '0;
      lflag = 1'b1;
      {fails, samples_checked, cyc} = '0;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset;
      t_causes;
      t_mask;
      t_busy;
      t_prio;
      final_report;
   end
endmodule : dic_controller_tb_top
